// [hdl/hbfm_pkg.sv]
// Purpose: Shared constants and carriers of the half-bridge fault monitor
// Assumes: Core clock of 200 MHz; serial words are 16 bits, LSB first
// Notes:   Word layouts are packed structs, MSB declared first
package hbfm_pkg;
    // Widths
    localparam int WORD_W = 16;                  // Serial word width
    localparam int CNT_W  = 4;                   // Bit counter width
    localparam int NSW    = 6;                   // Switches LS1,HS1,LS2,HS2,LS3,HS3
    localparam int TMR_W  = 22;                  // Delay timer width
    // Times
    localparam int CLK_MHZ     = 200;            // Core clock rate
    localparam int SC_LONG_US  = 12000;          // Long short-circuit delay
    localparam int SC_SHORT_US = 1500;           // Short short-circuit delay
    localparam int UV_DELAY_US = 10;             // Undervoltage delay
    localparam int SC_LONG_CYC  = SC_LONG_US * CLK_MHZ;
    localparam int SC_SHORT_CYC = SC_SHORT_US * CLK_MHZ;
    localparam logic [TMR_W-1:0] UV_LIM = TMR_W'(UV_DELAY_US * CLK_MHZ - 1);
    // Serial constants
    localparam logic [CNT_W-1:0]  LAST_BIT = 4'hf;     // Index of last bit
    localparam logic [WORD_W-1:0] CMD_RST  = 16'he000; // Enable, long delay, test off
    localparam logic [WORD_W-1:0] ALL_ONES = 16'hffff; // Shutdown status
    // Command word from host
    typedef struct packed {
        logic       se;                          // Software enable
        logic       short_delay_select;          // High selects long delay
        logic       open_load_test_enable;       // Low runs the test
        logic       hs3;
        logic       ls3;
        logic [1:0] nu2;
        logic       hs2;
        logic       ls2;
        logic [1:0] nu1;
        logic       hs1;
        logic       ls1;
        logic [1:0] nu0;
        logic       status_reset_cmd;            // One-shot clear
    } hbfm_cmd_t;
    // Status word to host
    typedef struct packed {
        logic       supply_fail_flag;
        logic       en;
        logic       short_detected_flag;
        logic       hs3;
        logic       ls3;
        logic [1:0] nu2;
        logic       hs2;
        logic       ls2;
        logic [1:0] nu1;
        logic       hs1;
        logic       ls1;
        logic [1:0] nu0;
        logic       thermal_warning_flag;
    } hbfm_stat_t;
    // Comparator and pin inputs
    typedef struct packed {
        logic [NSW-1:0] oc;                      // Over current per switch
        logic [NSW-1:0] load;                    // Output level sense
        logic           tw;                      // Above warning threshold
        logic           ts;                      // Above shutdown threshold
        logic           uv;                      // Supply below lockout
        logic           hw_en;                   // Hardware enable pin
    } hbfm_sense_t;
endpackage

// [hdl/hbfm_top.sv]
// Purpose: Protection, diagnostics and serial command of a triple half bridge
// Assumes: Comparators and pins are asynchronous; sclk idles between frames
// Notes:   Serial shift-in on sclk rise; status bits advance on core clock
//
// Behaviour
// - Open-load test reports idle output level
// - Over current starts a per-switch timer
// - Timed-out overload latches flag, disables switch
// - Status reset clears flag, re-enables switches
// - Warning flag follows warning comparator
// - Warning bit appears at chip-select fall
// - Early chip-select rise aborts, changes nothing
// - Shutdown turns switches off, status all ones
// - Resume needs cool die and status reset
// - Undervoltage timer expiry sets flag, disables
// - Supply recovery resumes outputs at once
// - Supply flag stays until status reset
// - Fault pin low on over current, trip or shutdown
// - Fault pin held until normal operation
// - Delay select: 12 ms high, 1.5 ms low
// - Short flag at status bit 13
// - Supply flag at status bit 15
// - Warning flag at status bit 0
`timescale 1ns/1ps
`default_nettype none
module hbfm_top #(
    parameter int SC_LONG_CYC  = hbfm_pkg::SC_LONG_CYC,
    parameter int SC_SHORT_CYC = hbfm_pkg::SC_SHORT_CYC
) (
    // Core clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // Analog comparators and enable pin
    input  wire hbfm_pkg::hbfm_sense_t sense,
    // Serial link
    input  wire logic                  sclk,
    input  wire logic                  cs_b,
    input  wire logic                  sdi,
    output var  logic                  sdo,
    output var  logic                  sdo_oe,
    // Open-drain fault pin
    output var  logic                  fault_n_o,
    output var  logic                  fault_n_oe,
    // Power stage drives
    output var  logic [5:0]            sw_on,
    output var  logic                  ol_pulldown
);
    import hbfm_pkg::*;

    // Link domain state
    logic [WORD_W-1:0] rx_sh_q;                  // Shift register
    logic [CNT_W-1:0]  rx_cnt_q;                 // Bits in this frame
    logic [WORD_W-1:0] rx_word_q;                // Last complete word
    logic              rx_done_tgl_q;            // Toggles per word
    logic              rx_bit_tgl_q;             // Toggles per bit
    logic              lrst_q;                   // Link reset, core side
    // Core domain state
    hbfm_sense_t       sen_m_q, sen_q;           // Input synchroniser
    logic [2:0]        cs_q, done_q, bit_q;      // Link synchronisers
    hbfm_cmd_t         cmd_q;                    // Committed command
    logic              srr_q;                    // Status reset pulse
    logic [NSW-1:0]    sc_off_q;                 // Switches off by overload
    wire  [NSW-1:0]    trip;                     // Timer expiry per switch
    logic              shut_q;                   // Thermal shutdown latch
    logic [TMR_W-1:0]  uv_tmr_q;                 // Undervoltage timer
    logic              uv_off_q;                 // Outputs off by supply
    logic              psf_q;                    // Supply fail flag
    hbfm_stat_t        stat_d, stat_q;           // Status word
    logic [WORD_W-1:0] tx_q;                     // Outgoing shifter
    logic [NSW-1:0]    want, sw_d;               // Requested, allowed
    logic [TMR_W-1:0]  sc_lim;                   // Selected delay
    logic              enable;                   // Software and pin enable

    // Link reset follows core reset
    always_ff @(posedge core_clk) begin
        lrst_q <= !rst_b;
    end

    // Bit counter, cleared whenever chip select is high
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            rx_cnt_q <= '0;
        end else begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
        end
    end

    // Shift in LSB first; commit only a full word
    always_ff @(posedge sclk or posedge lrst_q) begin
        if (lrst_q) begin
            rx_sh_q       <= '0;
            rx_word_q     <= CMD_RST;
            rx_done_tgl_q <= 1'b0;
            rx_bit_tgl_q  <= 1'b0;
        end else if (!cs_b) begin
            rx_sh_q      <= {sdi, rx_sh_q[WORD_W-1:1]};
            rx_bit_tgl_q <= ~rx_bit_tgl_q;
            if (rx_cnt_q == LAST_BIT) begin
                rx_word_q     <= {sdi, rx_sh_q[WORD_W-1:1]};
                rx_done_tgl_q <= ~rx_done_tgl_q;
            end
        end
    end

    // Synchronisers; stage 0 read only by stage 1
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sen_m_q <= '0;
            sen_q   <= '0;
            cs_q    <= 3'h7;
            done_q  <= 3'h0;
            bit_q   <= 3'h0;
        end else begin
            sen_m_q <= sense;
            sen_q   <= sen_m_q;
            cs_q    <= {cs_q[1:0], cs_b};
            done_q  <= {done_q[1:0], rx_done_tgl_q};
            bit_q   <= {bit_q[1:0], rx_bit_tgl_q};
        end
    end

    // Command commit; reset request lasts one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cmd_q <= hbfm_cmd_t'(CMD_RST);
            srr_q <= 1'b0;
        end else if (done_q[2] != done_q[1]) begin
            cmd_q <= hbfm_cmd_t'(rx_word_q);
            srr_q <= rx_word_q[0];
        end else begin
            srr_q <= 1'b0;
        end
    end

    // Delay select
    always_comb begin
        sc_lim = cmd_q.short_delay_select ? TMR_W'(SC_LONG_CYC - 1)
                                          : TMR_W'(SC_SHORT_CYC - 1);
    end

    // One overload timer per switch
    for (genvar i = 0; i < NSW; i++) begin : g_sw
        logic [TMR_W-1:0] tmr_q;                 // Overload duration
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                tmr_q <= '0;
            end else if (sen_q.oc[i] && !sc_off_q[i]) begin
                tmr_q <= tmr_q + 1'b1;
            end else begin
                tmr_q <= '0;
            end
        end
        assign trip[i] = sen_q.oc[i] && !sc_off_q[i] && (tmr_q == sc_lim);
    end

    // Overload latch; a trip wins over a clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sc_off_q <= '0;
        end else begin
            sc_off_q <= (srr_q ? '0 : sc_off_q) | trip;
        end
    end

    // Thermal shutdown latch
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            shut_q <= 1'b0;
        end else if (sen_q.ts) begin
            shut_q <= 1'b1;
        end else if (srr_q) begin
            shut_q <= 1'b0;
        end
    end

    // Undervoltage timer and output lockout
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            uv_tmr_q <= '0;
            uv_off_q <= 1'b0;
        end else if (!sen_q.uv) begin
            uv_tmr_q <= '0;
            uv_off_q <= 1'b0;
        end else if (uv_tmr_q == UV_LIM) begin
            uv_off_q <= 1'b1;
        end else begin
            uv_tmr_q <= uv_tmr_q + 1'b1;
        end
    end

    // Supply fail flag; expiry wins over a clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            psf_q <= 1'b0;
        end else if (sen_q.uv && uv_tmr_q == UV_LIM) begin
            psf_q <= 1'b1;
        end else if (srr_q) begin
            psf_q <= 1'b0;
        end
    end

    // Allowed switch drives
    always_comb begin
        enable = cmd_q.se && sen_q.hw_en;
        want   = {cmd_q.hs3, cmd_q.ls3, cmd_q.hs2, cmd_q.ls2, cmd_q.hs1, cmd_q.ls1};
        sw_d   = want & ~sc_off_q;
        if (!enable || shut_q || uv_off_q) begin
            sw_d = '0;
        end
    end

    // Status word; open-load test reports output levels
    always_comb begin
        stat_d = '0;
        stat_d.thermal_warning_flag = sen_q.tw;
        stat_d.short_detected_flag  = |sc_off_q;
        stat_d.supply_fail_flag     = psf_q;
        stat_d.en                   = enable;
        if (!cmd_q.open_load_test_enable) begin
            {stat_d.hs3, stat_d.ls3, stat_d.hs2, stat_d.ls2, stat_d.hs1, stat_d.ls1} =
                sen_q.load;
        end else begin
            {stat_d.hs3, stat_d.ls3, stat_d.hs2, stat_d.ls2, stat_d.hs1, stat_d.ls1} =
                sw_on;
        end
        if (shut_q) begin
            stat_d = hbfm_stat_t'(ALL_ONES);
        end
    end

    // Output drives and fault pin
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sw_on       <= '0;
            ol_pulldown <= 1'b0;
            stat_q      <= '0;
            fault_n_o   <= 1'b0;
            fault_n_oe  <= 1'b0;
        end else begin
            sw_on       <= sw_d;
            ol_pulldown <= !cmd_q.open_load_test_enable;
            stat_q      <= stat_d;
            fault_n_o   <= 1'b0;
            fault_n_oe  <= (|sen_q.oc) || (|sc_off_q) || shut_q;
        end
    end

    // Serial output: bit 0 at chip-select fall, then one per sclk
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_q   <= '0;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= !cs_q[1];
            if (cs_q[2] && !cs_q[1]) begin
                tx_q <= stat_q;
                sdo  <= stat_q[0];
            end else if (!cs_q[1] && bit_q[2] != bit_q[1]) begin
                tx_q <= {1'b0, tx_q[WORD_W-1:1]};
                sdo  <= tx_q[1];
            end
        end
    end

    // Checks on the core clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_sc_trip;
        trip != '0 |=> ((sc_off_q & $past(trip)) == $past(trip))
            ##1 ((sw_on & $past(trip, 2)) == '0);
    endproperty
    a_sc_trip: assert property (p_sc_trip) else $error("overload did not latch");

    property p_sc_clear;
        srr_q && !(|sen_q.oc) |=> sc_off_q == '0;
    endproperty
    a_sc_clear: assert property (p_sc_clear) else $error("status reset left flag");

    property p_warn;
        !shut_q && !$past(shut_q) ##0 $stable(sen_q.tw) |=> stat_q[0] == $past(sen_q.tw);
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit wrong");

    property p_shut;
        shut_q |=> sw_on == '0 && stat_q == ALL_ONES;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown not enforced");

    property p_resume;
        shut_q && sen_q.ts |=> shut_q;
    endproperty
    a_resume: assert property (p_resume) else $error("hot die resumed");

    property p_uv_off;
        uv_off_q |=> sw_on == '0;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("outputs on under lockout");

    property p_uv_rec;
        !sen_q.uv |=> !uv_off_q;
    endproperty
    a_uv_rec: assert property (p_uv_rec) else $error("lockout held after recovery");

    property p_psf_hold;
        psf_q && !srr_q |=> psf_q;
    endproperty
    a_psf_hold: assert property (p_psf_hold) else $error("supply flag lost");

    property p_fault;
        shut_q || (|sc_off_q) |=> fault_n_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("fault pin released");

    property p_srr;
        srr_q |=> !srr_q;
    endproperty
    a_srr: assert property (p_srr) else $error("status reset not one-shot");

    // Main scenarios
    c_trip:   cover property (trip != '0);
    c_shut:   cover property (shut_q ##1 !shut_q);
    c_psf:    cover property ($rose(psf_q));
    c_commit: cover property (done_q[2] != done_q[1]);
endmodule
`default_nettype wire

// [verif/hbfm_host_model.sv]
// Purpose: Host side of the serial link of the fault monitor
// Assumes: Link clock of 30 ns that idles low between frames
// Notes:   Writes a command and reads the status word, LSB first
`timescale 1ns/1ps
`default_nettype none
module hbfm_host_model (
    // Link lines to the device
    output var  logic        sclk,
    output var  logic        cs_b,
    output var  logic        sdi,
    // Lines from the device
    input  wire logic        sdo,
    input  wire logic        sdo_oe,
    // Word read in the last frame
    output var  logic [15:0] rx
);
    event done;  // Frame finished

    // Idle link at time zero
    initial begin
        sclk = 1'b0;
        cs_b <= 1'b1;  // Late update gives the frame counter a clearing edge
        sdi  = 1'b0;
        rx   = 16'h0000;
    end

    // One frame of n bits; fewer than 16 ends it early
    task automatic xfer(input logic [15:0] w, input int n);
        rx = 16'h0000;
        #2.3 cs_b = 1'b0;
        #45;
        for (int k = 0; k < n; k++) begin
            sdi = w[k];  // Set up a half period before the rise
            #15 sclk = 1'b1;
            rx[k] = sdo_oe ? sdo : 1'bx;  // Undriven line reads unknown
            #15 sclk = 1'b0;
        end
        #20 cs_b = 1'b1;
        sdi = ~sdi;  // Released line shows no stale value
        -> done;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench of the half-bridge fault monitor
// Assumes: Overload delays shortened to 40 and 200 core cycles
// Notes:   Expected words and pin states queue up for two monitors
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hbfm_pkg::*;
    localparam int SCS = 40;                 // Short overload delay
    localparam int SCL = 200;                // Long overload delay
    localparam logic [15:0] M = 16'hf999;    // Defined status bits
    logic         core_clk = 1'b0;           // Core clock
    logic         rst_b = 1'b0;              // Core reset
    hbfm_sense_t  sense = 16'h0001;          // Comparators, enable high
    logic         sclk, cs_b, sdi, sdo, sdo_oe;
    logic         fault_n_o, fault_n_oe, ol_pulldown;
    logic [5:0]   sw_on;                     // Switch drives
    logic [15:0]  rx;                        // Word read by host
    logic [31:0]  q_w[$];                    // Expected words, masks
    logic [15:0]  q_p[$];                    // Expected pins, masks
    event         snap;                      // Pin sample request
    int           n_fail = 0;
    int           compares = 0;
    logic [5:0]   sw;                        // Random switch pattern
    int           idx;                       // Overloaded switch

    always #2.5 core_clk = ~core_clk;

    hbfm_top #(.SC_LONG_CYC(SCL), .SC_SHORT_CYC(SCS)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .sense(sense), .sclk(sclk),
        .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .sw_on(sw_on),
        .ol_pulldown(ol_pulldown));
    hbfm_host_model i_host (.sclk(sclk), .cs_b(cs_b), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .rx(rx));

    // Switch bits in word order LS1 at bit 3 up to HS3 at bit 12
    function automatic logic [11:0] sw2w(input logic [5:0] s);
        return {s[5], s[4], 2'b00, s[3], s[2], 2'b00, s[1], s[0], 2'b00};
    endfunction
    function automatic logic [15:0] cmd(input logic r, t, o, input logic [5:0] s);
        return {1'b1, t, o, sw2w(s), r};
    endfunction
    function automatic logic [15:0] st(input logic p, d, input logic [5:0] s, input logic w);
        return {p, 1'b1, d, sw2w(s), w};
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Queue the expected status, then run the frame
    task automatic frame(input logic [15:0] w, e, m, input int n);
        q_w.push_back({e & m, m});
        @(posedge core_clk);
        i_host.xfer(w, n);
        wt(10);
    endtask
    // Queue pin state {pulldown, fault pin, switches} and sample it
    task automatic pins(input logic [7:0] e, m);
        q_p.push_back({e & m, m});
        #1 -> snap;
        @(posedge core_clk);
    endtask
    task automatic chk_word(input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] status word exp %h got %h", e, g);
        end
    endtask
    task automatic chk_pins(input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] pins exp %h got %h", e, g);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Status monitor, one note per finished frame
    always @(i_host.done) begin
        logic [31:0] t;
        t = q_w.pop_front();
        chk_word(t[31:16], rx & t[15:0]);
    end
    // Pin monitor, open-drain pin pulled up when released
    always @(snap) begin
        logic [15:0] t;
        t = q_p.pop_front();
        chk_pins(t[15:8], {ol_pulldown, fault_n_oe ? fault_n_o : 1'b1, sw_on} & t[7:0]);
    end
    // Watchdog
    initial begin
        #250000;
        n_fail++;
        complete_run();
    end

    // Main sequence
    initial begin
        void'($urandom(32'he9c05545));
        sw = 6'($urandom);
        idx = int'($urandom % 6);
        sw[idx] = 1'b1;
        wt(8);
        rst_b <= 1'b1;
        wt(4);
        frame(cmd(0, 0, 1, sw), st(0, 0, 6'h00, 0), M, 16);
        pins({2'b01, sw}, 8'hff);
        // Overload with short then long delay; second latch proves one-shot clear
        for (int l = 0; l < 2; l++) begin
            sense.oc[idx] <= 1'b1;
            wt((l ? SCL : SCS) - 2);
            pins({2'b00, sw}, 8'hff);
            wt(8);
            pins({2'b00, sw & ~(6'h01 << idx)}, 8'hff);
            sense.oc[idx] <= 1'b0;
            wt(5);
            pins({2'b00, sw & ~(6'h01 << idx)}, 8'hff);
            frame(cmd(1, 1, 1, sw), st(0, 1, sw & ~(6'h01 << idx), 0), M, 16);
            pins({2'b01, sw}, 8'hff);
        end
        // Warning read by an aborted 15-bit frame
        sense.tw <= 1'b1;
        wt(10);
        frame(cmd(1, 0, 1, 6'h00), st(0, 0, sw, 1), 16'h7999, 15);
        pins({2'b01, sw}, 8'hff);
        sense.tw <= 1'b0;
        wt(10);
        frame(cmd(0, 1, 1, sw), st(0, 0, sw, 0), M, 16);
        // Supply dip shorter than the delay, then a long one
        sense.uv <= 1'b1;
        wt(1000);
        sense.uv <= 1'b0;
        wt(10);
        frame(cmd(0, 1, 1, sw), st(0, 0, sw, 0), M, 16);
        sense.uv <= 1'b1;
        wt(2010);
        pins({2'b01, 6'h00}, 8'hff);
        sense.uv <= 1'b0;
        wt(5);
        pins({2'b01, sw}, 8'hff);
        frame(cmd(1, 1, 1, sw), st(1, 0, sw, 0), M, 16);
        frame(cmd(0, 1, 1, sw), st(0, 0, sw, 0), M, 16);
        // Thermal shutdown; clear refused while hot
        sense.ts <= 1'b1;
        wt(6);
        pins({2'b00, 6'h00}, 8'hff);
        frame(cmd(1, 1, 1, sw), 16'hffff, 16'hffff, 16);
        pins({2'b00, 6'h00}, 8'hff);
        sense.ts <= 1'b0;
        wt(10);
        pins({2'b00, 6'h00}, 8'hff);
        frame(cmd(1, 1, 1, sw), 16'hffff, 16'hffff, 16);
        pins({2'b01, sw}, 8'hff);
        // Open-load test: all off, then one high side on
        frame(cmd(0, 1, 0, 6'h00), st(0, 0, sw, 0), M, 16);
        for (int c = 1; c >= 0; c--) begin
            sense.load <= {2'b00, c[0], 3'b010};
            wt(5);
            frame(cmd(0, 1, 0, 6'h02), st(0, 0, {2'b00, c[0], 3'b010}, 0), M, 16);
        end
        pins({2'b11, 6'h02}, 8'hff);
        complete_run();
    end
endmodule
`default_nettype wire
